/* File: tarfc_pkg.sv */
package tarfc_pkg;

	// Clock and time base
	localparam int unsigned CLK_HZ          = 40000000;           // System clock rate
	localparam int unsigned TICK_MS         = 100;                // Time base step in ms
	localparam int unsigned TICK_CYC        = CLK_HZ / 1000 * TICK_MS; // Cycles per time base step
	localparam int unsigned FAN_MIN_RUN_MS  = 600000;             // Fan least run time, 10 minutes
	localparam int unsigned FAN_MIN_TICKS   = FAN_MIN_RUN_MS / TICK_MS; // Steps in the least run time

	// Register byte offsets
	localparam logic [7:0] REG_RETRY_LIMIT  = 8'h00;              // retry_count_limit
	localparam logic [7:0] REG_RETRY_IVL    = 8'h04;              // retry_interval in time base steps
	localparam logic [7:0] REG_FAN_CTRL     = 8'h08;              // fan_control_select
	localparam logic [7:0] REG_OUT_ASSIGN   = 8'h0c;              // Output function assignments
	localparam logic [7:0] REG_STATUS       = 8'h10;              // Read-only state
	localparam logic [7:0] REG_COMMAND      = 8'h14;              // Write-only commands

	// Field positions
	localparam int unsigned OUT1_LSB        = 0;                  // output1_function_assign
	localparam int unsigned OUT2_LSB        = 8;                  // output2_function_assign
	localparam int unsigned RELAY_LSB       = 16;                 // relay_function_assign
	localparam int unsigned ST_TRIPPED      = 0;                  // Status: tripped
	localparam int unsigned ST_RETRY        = 1;                  // Status: retry in progress
	localparam int unsigned ST_ALARM        = 2;                  // Status: alarm raised
	localparam int unsigned ST_FAN          = 3;                  // Status: fan running
	localparam int unsigned ST_COUNT_LSB    = 8;                  // Status: attempt count
	localparam int unsigned CMD_MANUAL_RST  = 0;                  // Command: manual reset

	// Values and reset values
	localparam logic [7:0] FUNC_RETRY       = 8'h1a;              // Assignment code 26 selects retry status
	localparam logic [7:0] LIMIT_RST        = 8'h00;              // Retry disabled after reset
	localparam logic [7:0] IVL_RST          = 8'h05;              // Half a second
	localparam logic       FAN_SEL_RST      = 1'b0;               // Fan always on after reset
	localparam logic [1:0] RESP_OKAY        = 2'h0;               // AXI OKAY
	localparam logic [1:0] RESP_SLVERR      = 2'h2;               // AXI SLVERR

	// Trip causes as reported by the protection detectors
	typedef enum logic [3:0] {
		TRIP_OVERCURRENT,
		TRIP_OVERVOLTAGE,
		TRIP_HEATSINK_HOT,
		TRIP_BRAKE_RES_HOT,
		TRIP_MOTOR_HOT,
		TRIP_MOTOR_OVERLOAD,
		TRIP_INV_OVERLOAD,
		TRIP_UNDERVOLTAGE,
		TRIP_GROUND_FAULT,
		TRIP_EXTERNAL,
		TRIP_MEMORY_ERR,
		TRIP_OTHER
	} tarfc_trip_t;

	// Retry sequencer states
	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_WAIT,
		SEQ_ALARM
	} tarfc_seq_t;

endpackage : tarfc_pkg

/* File: tarfc_fan.sv */
`timescale 1ns/100ps
`default_nettype none

// Cooling fan on/off control with a least run time
module tarfc_fan
	import tarfc_pkg::*;
#(
	parameter int unsigned MIN_TICKS = FAN_MIN_TICKS
) (
	input  wire logic clk_sys,
	input  wire logic arst_n,
	input  wire logic tick,
	input  wire logic fan_control_select,
	input  wire logic drive_running,
	input  wire logic temp_below_threshold,
	output var  logic fan_on_q
);

	localparam int unsigned CW = $clog2(MIN_TICKS + 1);       // Run timer width
	localparam logic [CW-1:0] MIN_T = CW'(MIN_TICKS);         // Run timer end value

	logic [CW-1:0] run_q;                                     // Steps run since start
	logic          want_off;                                  // Conditions allow stopping

	// Stopping needs on/off mode, a stopped drive and a cool inside
	assign want_off = fan_control_select && !drive_running && temp_below_threshold; // [R6] [R8]

	// Fan state; a fresh start runs the least time, its first step possibly partial
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			fan_on_q <= 1'b1;
		end else if (!fan_on_q) begin
			// Restart as soon as the off conditions go away
			if (!want_off) begin
				fan_on_q <= 1'b1;
			end
		end else if (want_off && run_q >= MIN_T) begin
			fan_on_q <= 1'b0; // [R7]
		end
	end

	// Run timer; saturates so a long run never wraps into a short one
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			run_q <= '0;
		end else if (!fan_on_q) begin
			run_q <= '0;
		end else if (tick && run_q < MIN_T) begin
			run_q <= run_q + 1'b1; // [R7]
		end
	end

endmodule : tarfc_fan

`default_nettype wire

/* File: tarfc_top.sv */
`timescale 1ns/100ps
`default_nettype none

// Function
// R1: Retryable trip: wait interval, reset, restart silently
// R2: Alarm, no retry, once trips exceed limit
// R3: Limit zero disables retry entirely
// R4: Only seven listed trip causes are retried
// R5: Retry status on outputs assigned code 26
// R6: On/off mode stops fan when stopped, cool
// R7: Fan runs ten minutes least once started
// R8: Fan select 0 always on, 1 controlled
// R9: Manual reset or new limit clears count
module tarfc_top
	import tarfc_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = TICK_CYC,      // Cycles per 100 ms step
	parameter int unsigned FAN_TICKS   = FAN_MIN_TICKS  // Steps of least fan run time
) (
	input  wire logic        clk_sys,
	input  wire logic        arst_n,
	// AXI4-Lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output var  logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output var  logic        s_axi_wready,
	output var  logic [1:0]  s_axi_bresp,
	output var  logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output var  logic        s_axi_arready,
	output var  logic [31:0] s_axi_rdata,
	output var  logic [1:0]  s_axi_rresp,
	output var  logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Protection and drive
	input  wire logic        trip_valid,
	input  wire logic [3:0]  trip_cause,
	input  wire logic        drive_running,
	input  wire logic        temp_below_threshold,
	output var  logic        internal_reset_q,
	output var  logic        alarm_q,
	output var  logic        digital_output_one,
	output var  logic        digital_output_two,
	output var  logic        alarm_relay_output,
	output var  logic        fan_on
);

	localparam int unsigned TW = $clog2(TICK_CYCLES + 1);      // Divider width

	// Register state
	logic [7:0]  retry_count_limit_q;                          // Trips allowed a retry
	logic [7:0]  retry_interval_q;                             // Wait in 100 ms steps
	logic        fan_control_select_q;                         // 0 always on, 1 on/off
	logic [7:0]  out1_assign_q;                                // output1_function_assign
	logic [7:0]  out2_assign_q;                                // output2_function_assign
	logic [7:0]  relay_assign_q;                               // relay_function_assign
	// Bus state
	logic        aw_held_q;                                    // Write address taken
	logic        w_held_q;                                     // Write data taken
	logic [7:0]  aw_addr_q;                                    // Held write address
	logic [31:0] w_data_q;                                     // Held write data
	logic [3:0]  w_strb_q;                                     // Held byte enables
	logic        wr_fire;                                      // Write performed now
	logic        limit_wr;                                     // Limit register written
	logic        manual_rst;                                   // Manual reset command
	// Sequencer state
	tarfc_seq_t  seq_q;                                        // Retry sequencer state
	logic [7:0]  attempts_q;                                   // Trips counted so far
	logic [7:0]  wait_q;                                       // Steps waited since trip
	logic [TW-1:0] div_q;                                      // Time base divider
	logic        tick_q;                                       // One-cycle 100 ms pulse
	logic        retry_ok;                                     // This trip may be retried

	// Retryable causes; everything else goes straight to alarm
	function automatic logic cause_retryable(input logic [3:0] c);
		unique case (tarfc_trip_t'(c))
			TRIP_OVERCURRENT, TRIP_OVERVOLTAGE, TRIP_HEATSINK_HOT, TRIP_BRAKE_RES_HOT,
			TRIP_MOTOR_HOT, TRIP_MOTOR_OVERLOAD, TRIP_INV_OVERLOAD: cause_retryable = 1'b1; // [R4]
			default: cause_retryable = 1'b0;
		endcase
	endfunction : cause_retryable

	// Byte-lane merge of a write into an 8-bit field at a given lane
	function automatic logic [7:0] lane_merge(input logic [7:0] old, input logic [31:0] d,
	                                          input logic [3:0] s, input int unsigned lsb);
		lane_merge = s[lsb/8] ? d[lsb +: 8] : old;
	endfunction : lane_merge

	// Output routing: assignment code 26 shows the retry status
	function automatic logic route_out(input logic [7:0] assign_code, input logic fallback);
		route_out = (assign_code == FUNC_RETRY) ? (seq_q == SEQ_WAIT) : fallback; // [R5]
	endfunction : route_out

	assign wr_fire    = aw_held_q && w_held_q && !s_axi_bvalid;
	assign limit_wr   = wr_fire && aw_addr_q == REG_RETRY_LIMIT && w_strb_q[0];
	assign manual_rst = wr_fire && aw_addr_q == REG_COMMAND && w_strb_q[0] && w_data_q[CMD_MANUAL_RST];
	// Limit zero means no retry at all; a trip beyond the limit is refused
	assign retry_ok   = cause_retryable(trip_cause) && retry_count_limit_q != LIMIT_RST // [R3]
	                    && attempts_q < retry_count_limit_q; // [R2]

	// Write address channel; address held until the response is taken
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			aw_held_q     <= 1'b0;
			aw_addr_q     <= '0;
			s_axi_awready <= 1'b1;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_q     <= 1'b1;
			aw_addr_q     <= {s_axi_awaddr[7:2], 2'b00};
			s_axi_awready <= 1'b0;
		end else if (s_axi_bvalid && s_axi_bready) begin
			aw_held_q     <= 1'b0;
			s_axi_awready <= 1'b1;
		end
	end

	// Write data channel; may arrive before or after the address
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			w_held_q     <= 1'b0;
			w_data_q     <= '0;
			w_strb_q     <= '0;
			s_axi_wready <= 1'b1;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_q     <= 1'b1;
			w_data_q     <= s_axi_wdata;
			w_strb_q     <= s_axi_wstrb;
			s_axi_wready <= 1'b0;
		end else if (s_axi_bvalid && s_axi_bready) begin
			w_held_q     <= 1'b0;
			s_axi_wready <= 1'b1;
		end
	end

	// Write response one cycle after both halves are held
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			unique case (aw_addr_q)
				REG_RETRY_LIMIT, REG_RETRY_IVL, REG_FAN_CTRL,
				REG_OUT_ASSIGN, REG_STATUS, REG_COMMAND: s_axi_bresp <= RESP_OKAY;
				default: s_axi_bresp <= RESP_SLVERR;
			endcase
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Writable registers; status writes are accepted and ignored
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			retry_count_limit_q  <= LIMIT_RST;
			retry_interval_q     <= IVL_RST;
			fan_control_select_q <= FAN_SEL_RST;
			out1_assign_q        <= '0;
			out2_assign_q        <= '0;
			relay_assign_q       <= '0;
		end else if (wr_fire) begin
			unique case (aw_addr_q)
				REG_RETRY_LIMIT: retry_count_limit_q <= lane_merge(retry_count_limit_q, w_data_q, w_strb_q, 0);
				REG_RETRY_IVL:   retry_interval_q    <= lane_merge(retry_interval_q, w_data_q, w_strb_q, 0);
				REG_FAN_CTRL: begin
					if (w_strb_q[0]) begin
						fan_control_select_q <= w_data_q[0]; // [R8]
					end
				end
				REG_OUT_ASSIGN: begin
					out1_assign_q  <= lane_merge(out1_assign_q, w_data_q, w_strb_q, OUT1_LSB);
					out2_assign_q  <= lane_merge(out2_assign_q, w_data_q, w_strb_q, OUT2_LSB);
					relay_assign_q <= lane_merge(relay_assign_q, w_data_q, w_strb_q, RELAY_LSB);
				end
				default: ;
			endcase
		end
	end

	// Read channel; one read at a time, answer one cycle after the address
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= RESP_OKAY;
			s_axi_rdata   <= '0;
			unique case ({s_axi_araddr[7:2], 2'b00})
				REG_RETRY_LIMIT: s_axi_rdata[7:0] <= retry_count_limit_q;
				REG_RETRY_IVL:   s_axi_rdata[7:0] <= retry_interval_q;
				REG_FAN_CTRL:    s_axi_rdata[0]   <= fan_control_select_q;
				REG_OUT_ASSIGN:  s_axi_rdata[23:0] <= {relay_assign_q, out2_assign_q, out1_assign_q};
				REG_STATUS: begin
					s_axi_rdata[ST_TRIPPED]              <= seq_q != SEQ_IDLE;
					s_axi_rdata[ST_RETRY]                <= seq_q == SEQ_WAIT;
					s_axi_rdata[ST_ALARM]                <= alarm_q;
					s_axi_rdata[ST_FAN]                  <= fan_on;
					s_axi_rdata[ST_COUNT_LSB +: 8]       <= attempts_q;
				end
				REG_COMMAND: ;
				default: s_axi_rresp <= RESP_SLVERR;
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// 100 ms time base; a slow step keeps the wait counters narrow
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			div_q  <= '0;
			tick_q <= 1'b0;
		end else if (div_q == TW'(TICK_CYCLES - 1)) begin
			div_q  <= '0;
			tick_q <= 1'b1;
		end else begin
			div_q  <= div_q + 1'b1;
			tick_q <= 1'b0;
		end
	end

	// Retry sequencer; trips while already tripped are ignored
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			seq_q <= SEQ_IDLE;
		end else if (manual_rst) begin
			seq_q <= SEQ_IDLE;
		end else begin
			unique case (seq_q)
				SEQ_IDLE: begin
					if (trip_valid) begin
						seq_q <= retry_ok ? SEQ_WAIT : SEQ_ALARM; // [R2] [R3] [R4]
					end
				end
				SEQ_WAIT: begin
					// Interval counted from entry into the tripped state
					if (wait_q >= retry_interval_q) begin
						seq_q <= SEQ_IDLE; // [R1]
					end
				end
				SEQ_ALARM: ;
			endcase
		end
	end

	// Interval counter; a partial first step makes the wait up to 100 ms short
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			wait_q <= '0;
		end else if (seq_q != SEQ_WAIT) begin
			wait_q <= '0;
		end else if (tick_q && wait_q < retry_interval_q) begin
			wait_q <= wait_q + 1'b1; // [R1]
		end
	end

	// Attempt counter; kept across retries so repeated faults reach the limit
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			attempts_q <= '0;
		end else if (manual_rst || limit_wr) begin
			attempts_q <= '0; // [R9]
		end else if (seq_q == SEQ_IDLE && trip_valid && attempts_q != 8'hff) begin
			attempts_q <= attempts_q + 1'b1; // [R2]
		end
	end

	// Internal reset pulse at the end of the wait; no alarm on this path
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			internal_reset_q <= 1'b0;
		end else begin
			internal_reset_q <= seq_q == SEQ_WAIT && wait_q >= retry_interval_q && !manual_rst; // [R1]
		end
	end

	// Alarm follows the alarm state, cleared only by a manual reset
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			alarm_q <= 1'b0;
		end else if (manual_rst) begin
			alarm_q <= 1'b0;
		end else if (seq_q == SEQ_IDLE && trip_valid && !retry_ok) begin
			alarm_q <= 1'b1; // [R2] [R3]
		end
	end

	// Output terminals; the relay shows the alarm unless assigned to retry
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			digital_output_one <= 1'b0;
			digital_output_two <= 1'b0;
			alarm_relay_output <= 1'b0;
		end else begin
			digital_output_one <= route_out(out1_assign_q, 1'b0);  // [R5]
			digital_output_two <= route_out(out2_assign_q, 1'b0);  // [R5]
			alarm_relay_output <= route_out(relay_assign_q, alarm_q); // [R5]
		end
	end

	// Cooling fan controller on the shared time base
	tarfc_fan #(
		.MIN_TICKS(FAN_TICKS)
	) u_fan (
		.clk_sys             (clk_sys),
		.arst_n              (arst_n),
		.tick                (tick_q),
		.fan_control_select  (fan_control_select_q),
		.drive_running       (drive_running),
		.temp_below_threshold(temp_below_threshold),
		.fan_on_q            (fan_on)
	);

endmodule : tarfc_top

`default_nettype wire

/* File: tarfc_assertions.sv */
`timescale 1ns/100ps
`default_nettype none

// Port checks of retry sequencer, fan control and bus handshakes
module tarfc_assertions
	import tarfc_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = TICK_CYC,
	parameter int unsigned FAN_TICKS   = FAN_MIN_TICKS
) (
	input wire logic        clk_sys,
	input wire logic        arst_n,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        drive_running,
	input wire logic        temp_below_threshold,
	input wire logic        internal_reset_q,
	input wire logic        alarm_q,
	input wire logic        fan_on
);
	// First run step may be partial, so one step is allowed short; wide so the full ten minutes fit
	localparam longint MIN_RUN = longint'(FAN_TICKS - 1) * longint'(TICK_CYCLES);

	logic [63:0] run_q; // Cycles since the fan last started

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	// Fan run time, cleared while the fan stands
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			run_q <= '0;
		end else if (!fan_on) begin
			run_q <= '0;
		end else begin
			run_q <= run_q + 64'h1;
		end
	end

	// Both write channels taken at one edge
	sequence s_wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	// Read address taken
	sequence s_rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence

	// Both halves are held first, and the response is registered one edge later
	write_answer_a: assert property (s_wr_take |-> ##2 s_axi_bvalid)
		else $error("write response late");
	read_answer_a: assert property (s_rd_take |=> s_axi_rvalid && !s_axi_arready)
		else $error("read data late");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && !s_axi_awready)
		else $error("write response dropped");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	restart_pulse_a: assert property (internal_reset_q |=> !internal_reset_q)
		else $error("restart pulse too long");
	alarm_quiet_a: assert property (alarm_q |-> !internal_reset_q)
		else $error("restart while alarmed");
	alarm_clear_a: assert property ($fell(alarm_q) |-> $rose(s_axi_bvalid))
		else $error("alarm cleared without a write");
	fan_cause_a: assert property ($fell(fan_on) |-> !$past(drive_running) && $past(temp_below_threshold))
		else $error("fan stopped without cause");
	fan_back_a: assert property (drive_running || !temp_below_threshold |=> fan_on)
		else $error("fan not restarted");
	fan_min_run_a: assert property ($fell(fan_on) |-> run_q >= MIN_RUN)
		else $error("fan run time too short");

endmodule : tarfc_assertions

bind tarfc_top tarfc_assertions #(
	.TICK_CYCLES(TICK_CYCLES),
	.FAN_TICKS  (FAN_TICKS)
) tarfc_assertions_inst (.*);

`default_nettype wire

/* File: tarfc_prot_model.sv */
`timescale 1ns/100ps
`default_nettype none

// Trip detectors and drive state seen by the supervisor
module tarfc_prot_model (
	input  wire logic       clk_sys,
	output var  logic       trip_valid,
	output var  logic [3:0] trip_cause,
	output var  logic       drive_running,
	output var  logic       temp_below_threshold
);
	// Drive running and warm until told otherwise
	initial begin
		trip_valid = 1'b0;
		trip_cause = 4'hf;
		drive_running = 1'b1;
		temp_below_threshold = 1'b0;
	end

	// One-cycle trip; the cause is scrambled once the pulse ends
	task automatic fire(input logic [3:0] c);
		trip_valid <= 1'b1;
		trip_cause <= c;
		@(posedge clk_sys);
		trip_valid <= 1'b0;
		trip_cause <= ~c;
	endtask : fire

	// Running and cooling state
	task automatic env(input logic run, input logic cool);
		drive_running <= run;
		temp_below_threshold <= cool;
	endtask : env

endmodule : tarfc_prot_model

`default_nettype wire

/* File: tarfc_top_tb.sv */
`timescale 1ns/100ps
`default_nettype none

`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_count++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end

module tarfc_top_tb;
	import tarfc_pkg::*;
	localparam int T = 4; // Short time base step
	localparam int F = 3; // Short fan run in steps

	logic        clk_sys = 1'b0;
	logic        arst_n = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00;
	logic        s_axi_awvalid = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic        s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0;
	logic [7:0]  s_axi_araddr = 8'h00;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0;
	wire  logic  s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire  logic [1:0] s_axi_bresp, s_axi_rresp;
	wire  logic [31:0] s_axi_rdata;
	wire  logic  trip_valid, drive_running, temp_below_threshold;
	wire  logic [3:0] trip_cause;
	wire  logic  internal_reset_q, alarm_q, digital_output_one, digital_output_two;
	wire  logic  alarm_relay_output, fan_on;
	int          err_count = 0;
	int          total_checks = 0;
	logic [1:0]  resp;   // Last bus response
	logic [31:0] rd_q;   // Last read data

	always #12.5 clk_sys = ~clk_sys;

	tarfc_top #(.TICK_CYCLES(T), .FAN_TICKS(F)) tarfc_top_inst (
		.clk_sys(clk_sys), .arst_n(arst_n),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.trip_valid(trip_valid), .trip_cause(trip_cause), .drive_running(drive_running),
		.temp_below_threshold(temp_below_threshold), .internal_reset_q(internal_reset_q),
		.alarm_q(alarm_q), .digital_output_one(digital_output_one),
		.digital_output_two(digital_output_two), .alarm_relay_output(alarm_relay_output),
		.fan_on(fan_on));

	tarfc_prot_model tarfc_prot_model_inst (.clk_sys(clk_sys), .trip_valid(trip_valid),
		.trip_cause(trip_cause), .drive_running(drive_running),
		.temp_below_threshold(temp_below_threshold));

	// Bus write; ready is looked at mid-cycle, released after the taking edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, hb;
		int n;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		n = 0;
		do begin
			@(negedge clk_sys);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			hb = s_axi_bvalid;
			resp = s_axi_bresp;
			@(posedge clk_sys);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			n++;
		end while (!hb && n < 50);
		s_axi_bready <= 1'b0;
		if (!hb) err_count++;
	endtask : wr

	// Bus read into rd_q
	task automatic rd(input logic [7:0] a);
		logic ta, hr;
		int n;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		n = 0;
		do begin
			@(negedge clk_sys);
			ta = s_axi_arvalid && s_axi_arready;
			hr = s_axi_rvalid;
			rd_q = s_axi_rdata;
			resp = s_axi_rresp;
			@(posedge clk_sys);
			if (ta) s_axi_arvalid <= 1'b0;
			n++;
		end while (!hr && n < 50);
		s_axi_rready <= 1'b0;
		if (!hr) err_count++;
	endtask : rd

	// Read and compare masked data and response
	task automatic chk_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
		input logic [1:0] er);
		rd(a);
		`CHK(rd_q & m, e)
		`CHK(resp, er)
	endtask : chk_rd

	// Retried trip with interval 2; outputs {one,two,relay} checked mid-retry
	task automatic retry_once(input logic [3:0] c, input logic [2:0] e);
		int n;
		n = 0;
		tarfc_prot_model_inst.fire(c);
		do begin
			@(negedge clk_sys);
			n++;
			if (n == 2) `CHK({digital_output_one, digital_output_two, alarm_relay_output}, e)
		end while (internal_reset_q !== 1'b1 && n < 200);
		`CHK(n >= T && n <= 2 * T + 4, 1'b1)
		`CHK(alarm_q, 1'b0)
		repeat (2) @(posedge clk_sys);
	endtask : retry_once

	// Trip ending in alarm, then manual reset
	task automatic trip_alarm(input logic [3:0] c, input logic [7:0] cnt);
		tarfc_prot_model_inst.fire(c);
		@(posedge clk_sys);
		@(negedge clk_sys);
		`CHK({alarm_q, alarm_relay_output}, 2'b11)
		@(posedge clk_sys);
		chk_rd(REG_STATUS, 32'h0000ff04, {16'h0, cnt, 8'h04}, RESP_OKAY);
		wr(REG_COMMAND, 32'h1);
		`CHK(alarm_q, 1'b0)
		chk_rd(REG_STATUS, 32'h0000ff04, 32'h0, RESP_OKAY);
	endtask : trip_alarm

	// Waits for the fan to stop, counting cycles
	task automatic fan_off(output int n);
		n = 0;
		do begin
			@(negedge clk_sys);
			n++;
		end while (fan_on !== 1'b0 && n < 500);
		@(posedge clk_sys);
	endtask : fan_off

	// Reset values, read-only, write-only and unmapped places
	task automatic t_regs();
		chk_rd(REG_RETRY_LIMIT, '1, {24'h0, LIMIT_RST}, RESP_OKAY);
		chk_rd(REG_RETRY_IVL, '1, {24'h0, IVL_RST}, RESP_OKAY);
		chk_rd(REG_FAN_CTRL, '1, {31'h0, FAN_SEL_RST}, RESP_OKAY);
		chk_rd(REG_OUT_ASSIGN, '1, 32'h0, RESP_OKAY);
		chk_rd(REG_COMMAND, '1, 32'h0, RESP_OKAY);
		wr(8'h18, 32'hffffffff);
		`CHK(resp, RESP_SLVERR)
		chk_rd(8'h18, 32'h0, 32'h0, RESP_SLVERR);
		wr(REG_STATUS, 32'hffffffff);
		chk_rd(REG_STATUS, '1, 32'h00000008, RESP_OKAY);
	endtask : t_regs

	// Fan always on, then controlled with a least run time
	task automatic t_fan();
		int n;
		tarfc_prot_model_inst.env(1'b0, 1'b1);
		repeat (30) @(posedge clk_sys);
		`CHK(fan_on, 1'b1)
		wr(REG_FAN_CTRL, 32'h1);
		fan_off(n);
		`CHK(n <= 3 * T, 1'b1)
		tarfc_prot_model_inst.env(1'b1, 1'b1);
		repeat (2) @(posedge clk_sys);
		`CHK(fan_on, 1'b1)
		tarfc_prot_model_inst.env(1'b0, 1'b1);
		fan_off(n);
		`CHK(n >= (F - 1) * T - 1 && n <= F * T + 4, 1'b1)
		wr(REG_FAN_CTRL, 32'h0);
		repeat (2) @(posedge clk_sys);
		`CHK(fan_on, 1'b1)
	endtask : t_fan

	// Retries, count clear on limit write, limit exceeded, excluded causes
	task automatic t_retry();
		trip_alarm(4'h0, 8'h01);
		wr(REG_RETRY_IVL, 32'h2);
		wr(REG_OUT_ASSIGN, {8'h0, FUNC_RETRY, FUNC_RETRY, 8'h00});
		wr(REG_RETRY_LIMIT, 32'h7);
		retry_once(4'h0, 3'b011);
		wr(REG_OUT_ASSIGN, {24'h0, FUNC_RETRY});
		wr(REG_RETRY_LIMIT, 32'h7);
		chk_rd(REG_STATUS, 32'h0000ff00, 32'h0, RESP_OKAY);
		for (int c = 0; c < 7; c++) retry_once(c[3:0], 3'b100);
		trip_alarm(4'h0, 8'h08);
		for (int c = 7; c < 16; c++) trip_alarm(c[3:0], 8'h01);
	endtask : t_retry

	// Prints counts and verdict, ends the run
	task automatic final_report();
		$display("checks=%0d errors=%0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : final_report

	// Main sequence after two reset cycles
	initial begin
		repeat (2) @(posedge clk_sys);
		arst_n <= 1'b1;
		@(posedge clk_sys);
		t_regs();
		t_fan();
		t_retry();
		final_report();
	end

	// Watchdog well beyond the expected few hundred cycles
	initial begin
		#(25 * 40000);
		err_count++;
		final_report();
	end

endmodule : tarfc_top_tb

`default_nettype wire
